// file: common/gpgh_pkg.sv
// Package for the port G / port H general-purpose I/O block.
// Assumes a byte-wide register port and a single 100 MHz clock.
`default_nettype none

package gpgh_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Port widths
    // ------------------------------------------------------------
    localparam int G_PINS = 3;
    localparam int H_PINS = 2;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_G_LATCH = 8'h0A;
    localparam logic [7:0] OFF_H_LATCH = 8'h0B;
    localparam logic [7:0] OFF_G_DIR = 8'h0E;
    localparam logic [7:0] OFF_H_DIR = 8'h0F;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

endpackage : gpgh_pkg

`default_nettype wire

// file: core/gpgh_sync.sv
// Multi-bit two-flop synchroniser for asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence.
`default_nettype none

module gpgh_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // Refused at elaboration, before any logic is built
    if (WIDTH < 1) begin : g_bad_width
        $error("gpgh_sync: WIDTH must be at least 1");
    end

    // First stage is read only by the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule : gpgh_sync

`default_nettype wire

// file: core/gpgh_top.sv
// Port G (3 pins) and port H (2 pins) general-purpose I/O block.
// Assumes a plain register port on clk and pins from outside the domain.
// Operation
// - Port G direction one drives the pin, zero makes it an input.
// - Reset clears all port G direction bits.
// - Port G data read returns the latch where direction is one.
// - Port G data read returns the pin level where direction is zero.
// - Data latch writes always succeed, whatever the direction.
// - Port H has two pins, each with latch and direction bit.
// - Port H latches are writable and untouched by reset.
// - Enabled keyboard bits make port H pins interrupt inputs.
// - Port H direction one drives the pin, zero makes it an input.
// - Reset clears both port H direction bits.
// - Port H data read returns the latch where direction is one.
// - Port H data read returns the pin level where direction is zero.
// - Port G latches are writable and untouched by reset.
// - Enabled keyboard bits make port G pins interrupt inputs.
//
// Decided for this implementation: the strobed register port.
`default_nettype none

module gpgh_top #(
    parameter int G_WIDTH = gpgh_pkg::G_PINS,
    parameter int H_WIDTH = gpgh_pkg::H_PINS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [gpgh_pkg::ADDR_W-1:0] addr,
    input wire logic [gpgh_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [gpgh_pkg::DATA_W-1:0] rdata,
    input wire logic [G_WIDTH-1:0] g_pin_in,
    output logic [G_WIDTH-1:0] g_pin_out,
    output logic [G_WIDTH-1:0] g_pin_oe,
    input wire logic [H_WIDTH-1:0] h_pin_in,
    output logic [H_WIDTH-1:0] h_pin_out,
    output logic [H_WIDTH-1:0] h_pin_oe,
    input wire logic [G_WIDTH+H_WIDTH-1:0] keyboard_irq_enable_bits,
    output logic [G_WIDTH+H_WIDTH-1:0] keyboard_input_pins
);

    localparam int DW = gpgh_pkg::DATA_W;
    localparam int KW = G_WIDTH + H_WIDTH;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (G_WIDTH < 1 || G_WIDTH >= DW) begin : g_bad_g_width
        $error("gpgh_top: G_WIDTH out of range");
    end
    if (H_WIDTH < 1 || H_WIDTH >= DW) begin : g_bad_h_width
        $error("gpgh_top: H_WIDTH out of range");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hit(
        input logic [gpgh_pkg::ADDR_W-1:0] a,
        input logic [7:0] off
    );
        hit = (a == off);
    endfunction : hit

    // Per-bit choice between latch and pin on a data read
    function automatic logic [DW-1:0] pin_view(
        input logic [DW-1:0] dir,
        input logic [DW-1:0] latch,
        input logic [DW-1:0] pin
    );
        pin_view = (dir & latch) | (~dir & pin);
    endfunction : pin_view

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [KW-1:0] pin_s;
    logic [G_WIDTH-1:0] g_pin_s;
    logic [H_WIDTH-1:0] h_pin_s;

    gpgh_sync #(
        .WIDTH(KW)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({h_pin_in, g_pin_in}),
        .q(pin_s)
    );

    assign g_pin_s = pin_s[G_WIDTH-1:0];
    assign h_pin_s = pin_s[KW-1:G_WIDTH];

    // ------------------------------------------------------------
    // Data latches (no reset: contents survive a reset)
    // ------------------------------------------------------------
    logic [G_WIDTH-1:0] g_latch_r;
    logic [G_WIDTH-1:0] g_latch_nxt;
    logic [H_WIDTH-1:0] h_latch_r;
    logic [H_WIDTH-1:0] h_latch_nxt;

    always_comb begin
        g_latch_nxt = g_latch_r;
        h_latch_nxt = h_latch_r;
        if (wr_en && hit(addr, gpgh_pkg::OFF_G_LATCH)) begin
            g_latch_nxt = wdata[G_WIDTH-1:0];
        end
        if (wr_en && hit(addr, gpgh_pkg::OFF_H_LATCH)) begin
            h_latch_nxt = wdata[H_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        g_latch_r <= g_latch_nxt;
        h_latch_r <= h_latch_nxt;
    end

    // ------------------------------------------------------------
    // Direction registers and read port
    // ------------------------------------------------------------
    logic [G_WIDTH-1:0] g_dir_r;
    logic [G_WIDTH-1:0] g_dir_nxt;
    logic [H_WIDTH-1:0] h_dir_r;
    logic [H_WIDTH-1:0] h_dir_nxt;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic [KW-1:0] kbd_r;
    logic [KW-1:0] kbd_nxt;

    always_comb begin
        g_dir_nxt = g_dir_r;
        h_dir_nxt = h_dir_r;
        rdata_nxt = gpgh_pkg::RDATA_IDLE;
        if (wr_en && hit(addr, gpgh_pkg::OFF_G_DIR)) begin
            g_dir_nxt = wdata[G_WIDTH-1:0];
        end
        if (wr_en && hit(addr, gpgh_pkg::OFF_H_DIR)) begin
            h_dir_nxt = wdata[H_WIDTH-1:0];
        end
        // Unmapped reads answer zero rather than stale data
        if (rd_en) begin
            case (addr)
                gpgh_pkg::OFF_G_LATCH: begin
                    rdata_nxt = pin_view(
                        {{(DW-G_WIDTH){1'b0}}, g_dir_r},
                        {{(DW-G_WIDTH){1'b0}}, g_latch_r},
                        {{(DW-G_WIDTH){1'b0}}, g_pin_s});
                end
                gpgh_pkg::OFF_H_LATCH: begin
                    rdata_nxt = pin_view(
                        {{(DW-H_WIDTH){1'b0}}, h_dir_r},
                        {{(DW-H_WIDTH){1'b0}}, h_latch_r},
                        {{(DW-H_WIDTH){1'b0}}, h_pin_s});
                end
                gpgh_pkg::OFF_G_DIR: begin
                    rdata_nxt = {{(DW-G_WIDTH){1'b0}}, g_dir_r};
                end
                gpgh_pkg::OFF_H_DIR: begin
                    rdata_nxt = {{(DW-H_WIDTH){1'b0}}, h_dir_r};
                end
                default: begin
                    rdata_nxt = gpgh_pkg::RDATA_IDLE;
                end
            endcase
        end
        // Pin level seen by the keyboard module, driven pins included
        kbd_nxt = keyboard_irq_enable_bits & pin_s;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            g_dir_r <= gpgh_pkg::DIR_RESET[G_WIDTH-1:0];
            h_dir_r <= gpgh_pkg::DIR_RESET[H_WIDTH-1:0];
            rdata_r <= gpgh_pkg::RDATA_IDLE;
            kbd_r <= '0;
        end else begin
            g_dir_r <= g_dir_nxt;
            h_dir_r <= h_dir_nxt;
            rdata_r <= rdata_nxt;
            kbd_r <= kbd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Latch written before the direction flips keeps the pin clean
    assign g_pin_out = g_latch_r;
    assign g_pin_oe = g_dir_r;
    assign h_pin_out = h_latch_r;
    assign h_pin_oe = h_dir_r;
    assign rdata = rdata_r;
    assign keyboard_input_pins = kbd_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic g_dir_seen_r;
    logic h_dir_seen_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            g_dir_seen_r <= 1'b0;
            h_dir_seen_r <= 1'b0;
        end else begin
            if (wr_en && hit(addr, gpgh_pkg::OFF_G_DIR)) begin
                g_dir_seen_r <= 1'b1;
            end
            if (wr_en && hit(addr, gpgh_pkg::OFF_H_DIR)) begin
                h_dir_seen_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_g_dir_write: assert property (
        wr_en && addr == gpgh_pkg::OFF_G_DIR
        |=> g_pin_oe == $past(wdata[G_WIDTH-1:0]))
        else $error("port G enable does not follow direction write");

    a_h_dir_write: assert property (
        wr_en && addr == gpgh_pkg::OFF_H_DIR
        |=> h_pin_oe == $past(wdata[H_WIDTH-1:0]))
        else $error("port H enable does not follow direction write");

    a_g_dir_reset: assert property (
        !g_dir_seen_r |-> g_pin_oe == '0)
        else $error("port G pin driven before any direction write");

    a_h_dir_reset: assert property (
        !h_dir_seen_r |-> h_pin_oe == '0)
        else $error("port H pin driven before any direction write");

    a_g_read_out: assert property (
        rd_en && addr == gpgh_pkg::OFF_G_LATCH
        |=> (rdata[G_WIDTH-1:0] & $past(g_dir_r))
            == ($past(g_latch_r) & $past(g_dir_r)))
        else $error("port G read misses latch on output pins");

    a_g_read_in: assert property (
        rd_en && addr == gpgh_pkg::OFF_G_LATCH
        |=> (rdata[G_WIDTH-1:0] & ~$past(g_dir_r))
            == ($past(g_pin_s) & ~$past(g_dir_r)))
        else $error("port G read misses pin level on input pins");

    a_h_read_out: assert property (
        rd_en && addr == gpgh_pkg::OFF_H_LATCH
        |=> (rdata[H_WIDTH-1:0] & $past(h_dir_r))
            == ($past(h_latch_r) & $past(h_dir_r)))
        else $error("port H read misses latch on output pins");

    a_h_read_in: assert property (
        rd_en && addr == gpgh_pkg::OFF_H_LATCH
        |=> (rdata[H_WIDTH-1:0] & ~$past(h_dir_r))
            == ($past(h_pin_s) & ~$past(h_dir_r)))
        else $error("port H read misses pin level on input pins");

    a_g_latch_write: assert property (
        wr_en && addr == gpgh_pkg::OFF_G_LATCH
        |=> g_pin_out == $past(wdata[G_WIDTH-1:0]))
        else $error("port G latch write lost");

    a_h_latch_write: assert property (
        wr_en && addr == gpgh_pkg::OFF_H_LATCH
        |=> h_pin_out == $past(wdata[H_WIDTH-1:0]))
        else $error("port H latch write lost");

    a_latch_hold_both: assert property (
        !(wr_en && (addr == gpgh_pkg::OFF_G_LATCH
                    || addr == gpgh_pkg::OFF_H_LATCH))
        |=> $stable(g_pin_out) && $stable(h_pin_out))
        else $error("data latch changed without a write");

    a_kbd_pins: assert property (
        ##1 keyboard_input_pins
            == ($past(keyboard_irq_enable_bits) & $past(pin_s)))
        else $error("keyboard inputs do not follow enabled pins");

    a_rdata_idle: assert property (
        !rd_en |=> rdata == gpgh_pkg::RDATA_IDLE)
        else $error("read data not idle after no read");

    c_g_mixed_read: cover property (
        rd_en && addr == gpgh_pkg::OFF_G_LATCH
        && g_pin_oe != '0 && g_pin_oe != '1);

    c_write_latch_as_input: cover property (
        wr_en && addr == gpgh_pkg::OFF_H_LATCH && h_pin_oe == '0);

    c_dir_turn_on: cover property (
        wr_en && addr == gpgh_pkg::OFF_G_DIR && g_pin_oe == '0
        ##1 g_pin_oe != '0);

    c_kbd_active: cover property (keyboard_input_pins != '0);

endmodule : gpgh_top

`default_nettype wire

// file: testbench/gpgh_pin_model.sv
// Board-side model of the five port G and port H pins.
// Assumes the bench sets the level the board puts on undriven pins.
`default_nettype none

module gpgh_pin_model (
    input wire logic [2:0] g_oe,
    input wire logic [2:0] g_out,
    input wire logic [2:0] g_board,
    output logic [2:0] g_level,
    input wire logic [1:0] h_oe,
    input wire logic [1:0] h_out,
    input wire logic [1:0] h_board,
    output logic [1:0] h_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // The board source is weak, so an enabled buffer always wins
    assign g_level = (g_oe & g_out) | (~g_oe & g_board);
    assign h_level = (h_oe & h_out) | (~h_oe & h_board);

endmodule : gpgh_pin_model

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the port G / port H I/O block.
// Assumes the plain register port and the board pin model beside it.
`default_nettype none

`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, arst_n, wr_en, rd_en;
    logic [7:0] addr, wdata, rdata, rd;
    logic [2:0] g_in, g_out, g_oe, g_board;
    logic [1:0] h_in, h_out, h_oe, h_board;
    logic [4:0] kb_en, kb_pins;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;

    gpgh_top dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .g_pin_in(g_in),
        .g_pin_out(g_out), .g_pin_oe(g_oe), .h_pin_in(h_in),
        .h_pin_out(h_out), .h_pin_oe(h_oe),
        .keyboard_irq_enable_bits(kb_en), .keyboard_input_pins(kb_pins));

    gpgh_pin_model pins_model (.g_oe(g_oe), .g_out(g_out),
        .g_board(g_board), .g_level(g_in), .h_oe(h_oe), .h_out(h_out),
        .h_board(h_board), .h_level(h_in));

    // ------------------------------------------------------------
    // Bus tasks and closing
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        rd = rdata;
    endtask : rd_reg

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is under a hundred cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        g_board = 3'h2;
        h_board = 2'h1;
        kb_en = 5'h00;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd_reg(gpgh_pkg::OFF_G_DIR);
        `CHK(rd, 8'h00)
        rd_reg(gpgh_pkg::OFF_H_DIR);
        `CHK(rd, 8'h00)
        `CHK({h_oe, g_oe}, 5'h00)
        rd_reg(gpgh_pkg::OFF_G_LATCH);
        `CHK(rd, 8'h02)
        rd_reg(gpgh_pkg::OFF_H_LATCH);
        `CHK(rd, 8'h01)
        // Latches first so the pins never glitch when turned to output
        wr_reg(gpgh_pkg::OFF_G_LATCH, 8'h05);
        wr_reg(gpgh_pkg::OFF_H_LATCH, 8'h02);
        rd_reg(gpgh_pkg::OFF_G_LATCH);
        `CHK(rd, 8'h02)
        wr_reg(gpgh_pkg::OFF_G_DIR, 8'h05);
        settle(1);
        `CHK(g_oe, 3'h5)
        `CHK(g_out, 3'h5)
        wr_reg(gpgh_pkg::OFF_H_DIR, 8'h02);
        settle(1);
        `CHK(h_oe, 2'h2)
        `CHK(h_out, 2'h2)
        settle(3);
        rd_reg(gpgh_pkg::OFF_G_LATCH);
        `CHK(rd, 8'h07)
        @(posedge clk);
        #1;
        `CHK(rdata, 8'h00)
        rd_reg(gpgh_pkg::OFF_H_LATCH);
        `CHK(rd, 8'h03)
        @(posedge clk);
        g_board <= 3'h0;
        h_board <= 2'h0;
        settle(4);
        rd_reg(gpgh_pkg::OFF_G_LATCH);
        `CHK(rd, 8'h05)
        rd_reg(gpgh_pkg::OFF_H_LATCH);
        `CHK(rd, 8'h02)
        // Writes above the port width and to unmapped space are dropped
        wr_reg(gpgh_pkg::OFF_G_DIR, 8'hFF);
        rd_reg(gpgh_pkg::OFF_G_DIR);
        `CHK(rd, 8'h07)
        wr_reg(gpgh_pkg::OFF_G_DIR, 8'h05);
        wr_reg(8'h10, 8'hAA);
        rd_reg(8'h10);
        `CHK(rd, 8'h00)
        wr_reg(gpgh_pkg::OFF_H_LATCH, 8'h03);
        rd_reg(gpgh_pkg::OFF_H_LATCH);
        `CHK(rd, 8'h02)
        `CHK(h_out, 2'h3)
        wr_reg(gpgh_pkg::OFF_H_LATCH, 8'h02);
        g_board <= 3'h2;
        h_board <= 2'h1;
        kb_en <= 5'h15;
        settle(5);
        `CHK(kb_pins, 5'h15)
        @(posedge clk);
        kb_en <= 5'h0A;
        settle(2);
        `CHK(kb_pins, 5'h0A)
        @(posedge clk);
        arst_n <= 1'b0;
        settle(2);
        `CHK({h_oe, g_oe}, 5'h00)
        @(posedge clk);
        arst_n <= 1'b1;
        settle(1);
        `CHK(g_out, 3'h5)
        `CHK(h_out, 2'h2)
        settle(3);
        rd_reg(gpgh_pkg::OFF_G_LATCH);
        `CHK(rd, 8'h02)
        rd_reg(gpgh_pkg::OFF_H_DIR);
        `CHK(rd, 8'h00)
        // Write then read with no gap: the read must see the new value
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= gpgh_pkg::OFF_H_DIR;
        wdata <= 8'h01;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rdata, 8'h01)
        `CHK(h_oe, 2'h1)
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
